// *** rtl/phk_housekeeping.sv ***
`timescale 1ns/1ps
module phk_housekeeping (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input wire phk_pkg::phk_wb_req_type wb_req_i,
   output phk_pkg::phk_wb_rsp_type wb_rsp_o,
   // Logic pins
   input wire logic [phk_pkg::PIN_W-1:0] logic_in_i,
   input wire logic power_down_request_i,
   output logic [phk_pkg::PIN_W-1:0] out_pin_o,
   output logic [phk_pkg::PIN_W-1:0] out_oe_o,
   output logic powered_down_o
);

   // =============================================
   // Helper functions
   function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
      reg_hit = (adr[7:2] == ofs[7:2]);
   endfunction

   function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] sel);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      lane_merge = res;
   endfunction

   // =============================================
   // Power-up clear
   logic clear;
   logic ready;

   phk_por_seq u_por (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_o(clear),
      .ready_o(ready)
   );

   // =============================================
   // Pin synchronisers
   logic pd_meta_reg;
   logic pd_sync_reg;
   logic [phk_pkg::PIN_W-1:0] in_meta_reg;
   logic [phk_pkg::PIN_W-1:0] in_sync_reg;

   always_ff @(posedge clk_i) begin
      if (clear) begin
         pd_meta_reg <= 1'b0;
         pd_sync_reg <= 1'b0;
         in_meta_reg <= '0;
         in_sync_reg <= '0;
      end else begin
         pd_meta_reg <= power_down_request_i;
         pd_sync_reg <= pd_meta_reg;
         in_meta_reg <= logic_in_i;
         in_sync_reg <= in_meta_reg;
      end
   end

   // =============================================
   // Bus decode
   logic ack_reg;
   logic [31:0] dat_reg;
   logic access;
   logic wr;
   logic rd;
   logic [7:0] adr;
   logic [31:0] wdat;
   logic [3:0] sel;
   logic hit_sig_lo;
   logic hit_sig_hi;
   logic hit_arr_addr;
   logic hit_arr_data;
   logic hit_ctrl;
   logic hit_status;
   logic hit_checksum;
   logic hit_preload;

   assign adr = wb_req_i.adr;
   assign wdat = wb_req_i.dat;
   assign sel = wb_req_i.sel;
   assign access = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
   assign wr = access & wb_req_i.we;
   assign rd = access & ~wb_req_i.we;
   assign hit_sig_lo = reg_hit(adr, phk_pkg::SIG_LO_OFS);
   assign hit_sig_hi = reg_hit(adr, phk_pkg::SIG_HI_OFS);
   assign hit_arr_addr = reg_hit(adr, phk_pkg::ARR_ADDR_OFS);
   assign hit_arr_data = reg_hit(adr, phk_pkg::ARR_DATA_OFS);
   assign hit_ctrl = reg_hit(adr, phk_pkg::CTRL_OFS);
   assign hit_status = reg_hit(adr, phk_pkg::STATUS_OFS);
   assign hit_checksum = reg_hit(adr, phk_pkg::CHECKSUM_OFS);
   assign hit_preload = reg_hit(adr, phk_pkg::PRELOAD_OFS);

   // =============================================
   // Stored state
   phk_pkg::phk_prog_state_type state_reg;
   logic [phk_pkg::IDX_W-1:0] step_reg;
   logic [31:0] cfg_mem [phk_pkg::ARRAY_WORDS];
   logic [31:0] stage_mem [phk_pkg::ARRAY_WORDS];
   logic [phk_pkg::SIG_BITS-1:0] sig_reg;
   logic [phk_pkg::SIG_BITS-1:0] sig_stage_reg;
   logic [phk_pkg::IDX_W-1:0] arr_idx_reg;
   logic secured_reg;
   logic secure_stage_reg;
   logic refused_reg;
   logic [31:0] checksum_reg;

   logic busy;
   logic start_prog;
   logic last_step;
   logic refuse_set;
   logic refuse_clr;
   logic refused_next;
   logic [31:0] arr_read;
   logic [31:0] status_word;
   logic [31:0] rd_data;

   assign busy = (state_reg != phk_pkg::PHK_IDLE);
   assign start_prog = wr & hit_ctrl & sel[0] & wdat[phk_pkg::CTRL_PROGRAM_BIT] & ~busy;
   assign last_step = (step_reg == phk_pkg::LAST_IDX);

   assign arr_read = secured_reg ? phk_pkg::RST_WORD : cfg_mem[arr_idx_reg];
   assign refuse_set = rd & hit_arr_data & secured_reg;
   assign refuse_clr = wr & hit_status & sel[0] & wdat[phk_pkg::STAT_REFUSED_BIT];
   assign refused_next = refuse_set | (refused_reg & ~refuse_clr);

   assign status_word = {27'h0, ready, pd_sync_reg, refused_reg, secured_reg, busy};

   assign rd_data = hit_sig_lo ? sig_reg[31:0] :
                    hit_sig_hi ? sig_reg[63:32] :
                    hit_arr_addr ? {29'h0, arr_idx_reg} :
                    hit_arr_data ? arr_read :
                    hit_ctrl ? {30'h0, secure_stage_reg, 1'b0} :
                    hit_status ? status_word :
                    hit_checksum ? checksum_reg :
                    hit_preload ? {24'h0, out_pin_o} :
                    phk_pkg::RST_WORD;

   // =============================================
   // Bus answer
   always_ff @(posedge clk_i) begin
      if (clear) begin
         ack_reg <= 1'b0;
         dat_reg <= phk_pkg::RST_WORD;
      end else begin
         ack_reg <= access;
         dat_reg <= rd ? rd_data : phk_pkg::RST_WORD;
      end
   end

   assign wb_rsp_o.ack = ack_reg;
   assign wb_rsp_o.dat = dat_reg;

   // =============================================
   // Staging writes from software
   always_ff @(posedge clk_i) begin
      if (clear) begin
         sig_stage_reg <= '0;
         arr_idx_reg <= '0;
         secure_stage_reg <= 1'b0;
         refused_reg <= 1'b0;
         for (int i = 0; i < phk_pkg::ARRAY_WORDS; i++) begin
            stage_mem[i] <= phk_pkg::RST_WORD;
         end
      end else begin
         refused_reg <= refused_next;
         if (wr && hit_sig_lo) begin
            sig_stage_reg[31:0] <= lane_merge(sig_stage_reg[31:0], wdat, sel);
         end
         if (wr && hit_sig_hi) begin
            sig_stage_reg[63:32] <= lane_merge(sig_stage_reg[63:32], wdat, sel);
         end
         if (wr && hit_arr_addr && sel[0]) begin
            arr_idx_reg <= wdat[phk_pkg::IDX_W-1:0];
         end
         if (wr && hit_arr_data) begin
            stage_mem[arr_idx_reg] <= lane_merge(stage_mem[arr_idx_reg], wdat, sel);
         end
         if (start_prog) begin
            secure_stage_reg <= wdat[phk_pkg::CTRL_SECURE_BIT];
         end
      end
   end

   // =============================================
   // Programming cycle
   always_ff @(posedge clk_i) begin
      if (clear) begin
         state_reg <= phk_pkg::PHK_IDLE;
         step_reg <= '0;
      end else begin
         unique case (state_reg)
            phk_pkg::PHK_IDLE: begin
               if (start_prog) begin
                  state_reg <= phk_pkg::PHK_ERASE;
                  step_reg <= '0;
               end
            end
            phk_pkg::PHK_ERASE: begin
               step_reg <= step_reg + 1'b1;
               if (last_step) begin
                  state_reg <= phk_pkg::PHK_WRITE;
               end
            end
            phk_pkg::PHK_WRITE: begin
               step_reg <= step_reg + 1'b1;
               if (last_step) begin
                  state_reg <= phk_pkg::PHK_SIGN;
               end
            end
            phk_pkg::PHK_SIGN: begin
               state_reg <= phk_pkg::PHK_IDLE;
            end
         endcase
      end
   end

   // =============================================
   // Array, signature, protection, checksum
   always_ff @(posedge clk_i) begin
      if (clear) begin
         sig_reg <= '0;
         secured_reg <= 1'b0;
         checksum_reg <= phk_pkg::RST_WORD;
         for (int i = 0; i < phk_pkg::ARRAY_WORDS; i++) begin
            cfg_mem[i] <= phk_pkg::RST_WORD;
         end
      end else begin
         unique case (state_reg)
            phk_pkg::PHK_ERASE: begin
               cfg_mem[step_reg] <= phk_pkg::RST_WORD;
               checksum_reg <= phk_pkg::RST_WORD;
               if (last_step) begin
                  sig_reg <= '0;
                  secured_reg <= 1'b0;
               end
            end
            phk_pkg::PHK_WRITE: begin
               cfg_mem[step_reg] <= stage_mem[step_reg];
               checksum_reg <= checksum_reg + stage_mem[step_reg];
            end
            phk_pkg::PHK_SIGN: begin
               sig_reg <= sig_stage_reg;
               checksum_reg <= checksum_reg + sig_stage_reg[31:0] + sig_stage_reg[63:32];
               secured_reg <= secure_stage_reg;
            end
            phk_pkg::PHK_IDLE: begin
            end
         endcase
      end
   end

   // =============================================
   // Registered outputs
   logic [phk_pkg::PIN_W-1:0] polarity;
   logic [phk_pkg::PIN_W-1:0] enables;
   logic preload_wr;
   logic [phk_pkg::PIN_W-1:0] pin_next;

   assign polarity = cfg_mem[0][phk_pkg::CFG_POL_LSB +: phk_pkg::PIN_W];
   assign enables = cfg_mem[0][phk_pkg::CFG_OE_LSB +: phk_pkg::PIN_W];
   assign preload_wr = wr & hit_preload & sel[0];

   // array terms use only logic inputs
   assign pin_next = ~(in_sync_reg ^ polarity);

   always_ff @(posedge clk_i) begin
      if (clear) begin
         out_pin_o <= phk_pkg::RST_PIN;
         out_oe_o <= phk_pkg::RST_OE;
         powered_down_o <= 1'b0;
      end else begin
         powered_down_o <= pd_sync_reg;
         if (!pd_sync_reg) begin
            out_oe_o <= enables;
            if (preload_wr) begin
               out_pin_o <= wdat[phk_pkg::PIN_W-1:0];
            end else begin
               out_pin_o <= pin_next;
            end
         end
      end
   end

endmodule

// *** rtl/phk_pkg.sv ***
// =============================================
// Housekeeping constants and types
package phk_pkg;

   // =============================================
   // Sizes
   localparam int SIG_BITS = 64;
   localparam int PIN_W = 8;
   localparam int ARRAY_WORDS = 8;
   localparam int IDX_W = 3;
   localparam int ADR_W = 8;

   // =============================================
   // Register byte offsets
   localparam logic [7:0] SIG_LO_OFS = 8'h00;
   localparam logic [7:0] SIG_HI_OFS = 8'h04;
   localparam logic [7:0] ARR_ADDR_OFS = 8'h08;
   localparam logic [7:0] ARR_DATA_OFS = 8'h0C;
   localparam logic [7:0] CTRL_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   localparam logic [7:0] CHECKSUM_OFS = 8'h18;
   localparam logic [7:0] PRELOAD_OFS = 8'h1C;

   // =============================================
   // Field positions
   localparam int CTRL_PROGRAM_BIT = 0;
   localparam int CTRL_SECURE_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_SECURED_BIT = 1;
   localparam int STAT_REFUSED_BIT = 2;
   localparam int STAT_PDOWN_BIT = 3;
   localparam int STAT_READY_BIT = 4;
   localparam int CFG_POL_LSB = 0;
   localparam int CFG_OE_LSB = 8;

   // =============================================
   // Reset values and last array index
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [7:0] RST_PIN = 8'hFF;
   localparam logic [7:0] RST_OE = 8'h00;
   localparam logic [IDX_W-1:0] LAST_IDX = 3'h7;

   // =============================================
   // Power-up timing
   localparam int PWRUP_TIME_NS = 10000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int PWRUP_CYCLES = PWRUP_TIME_NS / CLK_PERIOD_NS;
   localparam int PWRUP_CNT_W = $clog2(PWRUP_CYCLES);

   // =============================================
   // Bus carriers and states
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [ADR_W-1:0] adr;
      logic [31:0] dat;
   } phk_wb_req_type;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } phk_wb_rsp_type;

   typedef enum logic [1:0] {
      PHK_IDLE,
      PHK_ERASE,
      PHK_WRITE,
      PHK_SIGN
   } phk_prog_state_type;

endpackage

// *** rtl/phk_por_seq.sv ***
`timescale 1ns/1ps
// =============================================
// Power-up clear sequencer
module phk_por_seq (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Sequencer state
   output logic clear_o,
   output logic ready_o
);

   logic [phk_pkg::PWRUP_CNT_W-1:0] cnt_reg;
   logic cnt_done;

   assign cnt_done = (cnt_reg == phk_pkg::PWRUP_CNT_W'(phk_pkg::PWRUP_CYCLES - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
         clear_o <= 1'b1;
         ready_o <= 1'b0;
      end else if (!cnt_done) begin
         cnt_reg <= cnt_reg + 1'b1;
      end else begin
         clear_o <= 1'b0;
         ready_o <= 1'b1;
      end
   end

endmodule

// *** tb/phk_sys_model.sv ***
`timescale 1ns/1ps
// =============================================
// System glue driving the logic pins
module phk_sys_model (
   // Clock
   input wire logic clk_i,
   // Requested levels
   input wire logic [phk_pkg::PIN_W-1:0] level_i,
   input wire logic pd_i,
   // Pins toward the device
   output logic [phk_pkg::PIN_W-1:0] logic_in_o,
   output logic power_down_request_o
);
   always @(posedge clk_i) begin
      logic_in_o <= level_i;
      power_down_request_o <= pd_i;
   end
endmodule

// *** tb/phk_housekeeping_props.sv ***
`timescale 1ns/1ps
// =============================================
// Bus and pin checks
module phk_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire phk_pkg::phk_wb_req_type wb_req_i,
   input wire phk_pkg::phk_wb_rsp_type wb_rsp_o,
   input wire logic [phk_pkg::PIN_W-1:0] logic_in_i,
   input wire logic power_down_request_i,
   input wire logic [phk_pkg::PIN_W-1:0] out_pin_o,
   input wire logic [phk_pkg::PIN_W-1:0] out_oe_o,
   input wire logic powered_down_o
);
   int cnt;
   logic ready;
   logic clearing;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 0;
      end else if (cnt < 1000) begin
         cnt <= cnt + 1;
      end
   end
   assign ready = cnt > phk_pkg::PWRUP_CYCLES + 4;
   assign clearing = cnt > 0 && cnt < phk_pkg::PWRUP_CYCLES;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence req_s;
      wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && ready;
   endsequence
   sequence pd_low_s;
      (!power_down_request_i)[*4];
   endsequence
   sequence preload_s;
      wb_rsp_o.ack && wb_req_i.we && wb_req_i.adr == phk_pkg::PRELOAD_OFS && wb_req_i.sel[0];
   endsequence
   ack_delay_a: assert property (req_s |=> wb_rsp_o.ack)
      else $error("ack missing one cycle after request");
   ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack longer than one cycle");
   dat_quiet_a: assert property ((!wb_rsp_o.ack || wb_req_i.we) |-> wb_rsp_o.dat == 32'h0)
      else $error("read data outside read ack");
   clear_pins_a: assert property (clearing |-> out_pin_o == 8'hFF && out_oe_o == 8'h00)
      else $error("pins not high during clear");
   clear_regs_a: assert property (clearing |-> !powered_down_o && !wb_rsp_o.ack)
      else $error("state not cleared during clear");
   pd_enter_a: assert property (power_down_request_i[*4] ##0 ready |-> powered_down_o)
      else $error("power-down not entered");
   pd_leave_a: assert property (pd_low_s ##0 ready |-> !powered_down_o)
      else $error("power-down not left");
   pd_freeze_a: assert property (powered_down_o && $past(powered_down_o) |->
      $stable(out_pin_o) && $stable(out_oe_o))
      else $error("outputs moved in power-down");
   preload_pins_a: assert property (pd_low_s ##0 preload_s |-> out_pin_o == wb_req_i.dat[7:0])
      else $error("preload value not on pins");
endmodule

bind phk_housekeeping phk_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
   .wb_rsp_o(wb_rsp_o), .logic_in_i(logic_in_i), .power_down_request_i(power_down_request_i),
   .out_pin_o(out_pin_o), .out_oe_o(out_oe_o), .powered_down_o(powered_down_o));

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
   logic clk_i;
   logic rst_i;
   phk_pkg::phk_wb_req_type req;
   phk_pkg::phk_wb_rsp_type rsp;
   logic [7:0] lvl, logic_in, out_pin, out_oe, pin_at_ack;
   logic pd, pd_req, pdn;
   int fails, n_compared, cycles;
   localparam logic [31:0] LO = 32'hC0DE_0000;
   localparam logic [31:0] HI = 32'h5EED_0000;
   phk_housekeeping u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
      .logic_in_i(logic_in), .power_down_request_i(pd_req), .out_pin_o(out_pin),
      .out_oe_o(out_oe), .powered_down_o(pdn));
   phk_sys_model u_sys (.clk_i(clk_i), .level_i(lvl), .pd_i(pd), .logic_in_o(logic_in),
      .power_down_request_o(pd_req));
   initial begin
      clk_i = 1'b0;
      #100;
      forever #12.5 clk_i = ~clk_i;
   end
   function automatic logic [31:0] word(input int i, input int k);
      return (i == 0) ? 32'h0000_FF0F : 32'h1357_0000 + 32'(i * 16 + k);
   endfunction
   function automatic logic [31:0] csum(input int k);
      logic [31:0] s;
      s = LO + HI + 32'(2 * k);
      for (int i = 0; i < 8; i++) s += word(i, k);
      return s;
   endfunction
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: wd};
      do @(posedge clk_i); while (rsp.ack !== 1'b1);
      rd = rsp.dat;
      pin_at_ack = out_pin;
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, adr, d, x);
   endtask
   task automatic rd(input logic [7:0] adr, input logic [31:0] e, input string nm);
      logic [31:0] x;
      xfer(1'b0, adr, 32'h0, x);
      `CHK(nm, e, x)
   endtask
   task automatic prog(input int k, input logic [31:0] ctrl);
      logic [31:0] x;
      for (int i = 0; i < 8; i++) begin
         wr(phk_pkg::ARR_ADDR_OFS, 32'(i));
         wr(phk_pkg::ARR_DATA_OFS, word(i, k));
      end
      wr(phk_pkg::SIG_LO_OFS, LO + 32'(k));
      wr(phk_pkg::SIG_HI_OFS, HI + 32'(k));
      wr(phk_pkg::CTRL_OFS, ctrl);
      do xfer(1'b0, phk_pkg::STATUS_OFS, 32'h0, x); while (x[0] !== 1'b0);
   endtask
   task automatic stop_test();
      $display("compared %0d fails %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      rst_i = 1'b1;
      req = '0;
      lvl = 8'h3C;
      pd = 1'b0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK("pin_clear", 8'hFF, out_pin)
      `CHK("oe_clear", 8'h00, out_oe)
      repeat (400) @(posedge clk_i);
      rd(phk_pkg::STATUS_OFS, 32'h10, "status_ready");
      rd(8'h20, 32'h0, "unmapped");
      prog(1, 32'h3);
      rd(phk_pkg::SIG_LO_OFS, LO + 32'h1, "sig_lo");
      rd(phk_pkg::SIG_HI_OFS, HI + 32'h1, "sig_hi");
      rd(phk_pkg::CHECKSUM_OFS, csum(1), "checksum");
      rd(phk_pkg::ARR_DATA_OFS, 32'h0, "secured_word");
      rd(phk_pkg::STATUS_OFS, 32'h16, "status_refused");
      wr(phk_pkg::STATUS_OFS, 32'h4);
      wr(phk_pkg::CTRL_OFS, 32'h0);
      rd(phk_pkg::STATUS_OFS, 32'h12, "status_kept");
      prog(2, 32'h1);
      rd(phk_pkg::STATUS_OFS, 32'h10, "status_open");
      wr(phk_pkg::ARR_ADDR_OFS, 32'h0);
      rd(phk_pkg::ARR_DATA_OFS, word(0, 2), "word0");
      rd(phk_pkg::CHECKSUM_OFS, csum(2), "checksum2");
      `CHK("oe_cfg", 8'hFF, out_oe)
      `CHK("pin_pol", 8'hCC, out_pin)
      wr(phk_pkg::PRELOAD_OFS, 32'h5A);
      `CHK("preload_a", 8'h5A, pin_at_ack)
      wr(phk_pkg::PRELOAD_OFS, 32'hA5);
      `CHK("preload_b", 8'hA5, pin_at_ack)
      pd <= 1'b1;
      repeat (5) @(posedge clk_i);
      rd(phk_pkg::STATUS_OFS, 32'h18, "status_pd");
      lvl <= 8'hC3;
      repeat (5) @(posedge clk_i);
      `CHK("pin_frozen", 8'hCC, out_pin)
      `CHK("pd_flag", 1'b1, pdn)
      pd <= 1'b0;
      repeat (5) @(posedge clk_i);
      `CHK("pd_off", 1'b0, pdn)
      `CHK("pin_run", 8'h33, out_pin)
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK("pin_reset", 8'hFF, out_pin)
      `CHK("oe_reset", 8'h00, out_oe)
      repeat (402) @(posedge clk_i);
      rd(phk_pkg::SIG_LO_OFS, 32'h0, "sig_cleared");
      stop_test();
   end
endmodule
